// ==== gpi_pull_level_config.sv ====
// Purpose: column level readback, row/column pull select, row irq polarity
// Assumes: pins asynchronous; register port one read cycle latency
// Notes:   factory option straps are parameters, pull reset values likewise
`include "gpi_pull_params.svh"
module gpi_pull_level_config #(
   parameter logic       HAS_ROW5          = 1'b0,
   parameter logic       HAS_INPUT6        = 1'b0,
   parameter logic [7:0] ROW_PULL_LOW_RST  = `PULL_RESET,
   parameter logic [7:0] ROW_PULL_HIGH_RST = `PULL_RESET,
   parameter logic [7:0] COL_PULL_LOW_RST  = `PULL_RESET,
   parameter logic [7:0] COL_PULL_HIGH_RST = `PULL_RESET
) (
   // Clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rst_in,
   // Register port
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_write_in,
   input  wire logic       reg_read_in,
   output logic      [7:0] reg_rdata_out,
   // Pins
   input  wire logic [5:0] row_pin_in,
   input  wire logic [4:0] column_pin_in,
   // Pull resistor enables, one bit per pin
   output logic      [5:0] row_up_300k_out,
   output logic      [5:0] row_down_300k_out,
   output logic      [5:0] row_up_100k_out,
   output logic      [4:0] column_up_300k_out,
   output logic      [4:0] column_down_300k_out,
   output logic      [4:0] column_up_100k_out,
   // Row input flags, inputs 6..1
   output logic      [5:0] row_irq_flag_out
);
   localparam logic [7:0] ROW_HIGH_WMASK = HAS_ROW5 ? `ROW_PULL_HIGH_MASK
                           : (`ROW_PULL_HIGH_MASK & ~`ROW5_PULL_MASK);
   localparam logic [7:0] POL_WMASK = HAS_INPUT6 ? `ROW_IRQ_POL_MASK
                           : (`ROW_IRQ_POL_MASK & ~`INPUT6_POL_MASK);

   typedef struct packed {
      logic [7:0] row_pull_low;
      logic [7:0] row_pull_high;
      logic [7:0] col_pull_low;
      logic [7:0] col_pull_high;
      logic [7:0] row_irq_pol;
      logic [5:0] row_flag;
      logic [7:0] rdata;
      logic [5:0] up3_r;
      logic [5:0] dn3_r;
      logic [5:0] up1_r;
      logic [4:0] up3_c;
      logic [4:0] dn3_c;
      logic [4:0] up1_c;
   } cfg_state_t;

   cfg_state_t st;
   cfg_state_t next_st;
   logic [5:0] row_level;
   logic [4:0] column_level;
   logic [5:0] d_up3_r;
   logic [5:0] d_dn3_r;
   logic [5:0] d_up1_r;
   logic [4:0] d_up3_c;
   logic [4:0] d_dn3_c;
   logic [4:0] d_up1_c;
   logic [11:0] row_fields;
   logic [9:0]  col_fields;

   function automatic logic [7:0] masked_write(input logic [7:0] old,
                                               input logic [7:0] wd,
                                               input logic [7:0] m);
      masked_write = (wd & m) | (old & ~m);
   endfunction : masked_write

   pin_sync #(.WIDTH(6)) row_sync (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .pin_in      (row_pin_in),
      .level_out   (row_level)
   );
   pin_sync #(.WIDTH(5)) column_sync (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .pin_in      (column_pin_in),
      .level_out   (column_level)
   );

   assign row_fields = {st.row_pull_high[3:0], st.row_pull_low};
   assign col_fields = {st.col_pull_high[1:0], st.col_pull_low};

   genvar g;
   generate
      for (g = 0; g < `ROW_COUNT; g++) begin : row_dec
         pull_decode dec (
            .field_in      (row_fields[2*g+1:2*g]),
            .up_300k_out   (d_up3_r[g]),
            .down_300k_out (d_dn3_r[g]),
            .up_100k_out   (d_up1_r[g])
         );
      end
      for (g = 0; g < `COL_COUNT; g++) begin : col_dec
         pull_decode dec (
            .field_in      (col_fields[2*g+1:2*g]),
            .up_300k_out   (d_up3_c[g]),
            .down_300k_out (d_dn3_c[g]),
            .up_100k_out   (d_up1_c[g])
         );
      end
   endgenerate

   always_comb begin
      next_st = st;
      next_st.up3_r = d_up3_r;
      next_st.dn3_r = d_dn3_r;
      next_st.up1_r = d_up1_r;
      next_st.up3_c = d_up3_c;
      next_st.dn3_c = d_dn3_c;
      next_st.up1_c = d_up1_c;
      next_st.rdata = 8'h00;
      if (reg_read_in) begin
         case (reg_addr_in)
            `ADDR_INT_STAT_ROW:  next_st.rdata = {2'h0, st.row_flag};
            `ADDR_ROW_LEVEL:     next_st.rdata = {2'h0, row_level};
            `ADDR_COL_LEVEL:     next_st.rdata = {3'h0, column_level};
            `ADDR_ROW_PULL_LOW:  next_st.rdata = st.row_pull_low;
            `ADDR_ROW_PULL_HIGH: next_st.rdata = st.row_pull_high;
            `ADDR_COL_PULL_LOW:  next_st.rdata = st.col_pull_low;
            `ADDR_COL_PULL_HIGH: next_st.rdata = st.col_pull_high;
            `ADDR_ROW_IRQ_POL:   next_st.rdata = st.row_irq_pol;
            default:             next_st.rdata = 8'h00;
         endcase
         if (reg_addr_in == `ADDR_INT_STAT_ROW) begin
            next_st.row_flag = 6'h00;
         end
      end
      if (reg_write_in) begin
         case (reg_addr_in)
            `ADDR_ROW_PULL_LOW: next_st.row_pull_low = reg_wdata_in;
            `ADDR_ROW_PULL_HIGH: next_st.row_pull_high =
               masked_write(st.row_pull_high, reg_wdata_in,
                            ROW_HIGH_WMASK);
            `ADDR_COL_PULL_LOW: next_st.col_pull_low = reg_wdata_in;
            `ADDR_COL_PULL_HIGH: next_st.col_pull_high =
               masked_write(st.col_pull_high, reg_wdata_in,
                            `COL_PULL_HIGH_MASK);
            `ADDR_ROW_IRQ_POL: next_st.row_irq_pol =
               masked_write(st.row_irq_pol, reg_wdata_in,
                            POL_WMASK);
            default: ;
         endcase
      end
      // Level sensitive set, placed after the read clear so set wins
      for (int i = 0; i < `ROW_COUNT; i++) begin
         if (row_level[i] == st.row_irq_pol[i] && POL_WMASK[i]) begin
            next_st.row_flag[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st               <= '0;
         st.row_pull_low  <= ROW_PULL_LOW_RST;
         st.row_pull_high <= ROW_PULL_HIGH_RST & `ROW_PULL_HIGH_MASK;
         st.col_pull_low  <= COL_PULL_LOW_RST;
         st.col_pull_high <= COL_PULL_HIGH_RST & `COL_PULL_HIGH_MASK;
         st.row_irq_pol   <= `ROW_IRQ_POL_RESET;
         st.up3_r         <= '1;
         st.up3_c         <= '1;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata_out        = st.rdata;
   assign row_up_300k_out      = st.up3_r;
   assign row_down_300k_out    = st.dn3_r;
   assign row_up_100k_out      = st.up1_r;
   assign column_up_300k_out   = st.up3_c;
   assign column_down_300k_out = st.dn3_c;
   assign column_up_100k_out   = st.up1_c;
   assign row_irq_flag_out     = st.row_flag;
endmodule : gpi_pull_level_config

// ==== gpi_pull_params.svh ====
// Purpose: offsets, field positions and reset values of the pull/level slice
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   included only by the top configuration module of the block
`ifndef GPI_PULL_PARAMS_SVH
`define GPI_PULL_PARAMS_SVH
`define ADDR_INT_STAT_ROW      8'h13
`define ADDR_INT_STAT_COL      8'h14
`define ADDR_ROW_LEVEL         8'h15
`define ADDR_COL_LEVEL         8'h16
`define ADDR_ROW_PULL_LOW      8'h17
`define ADDR_ROW_PULL_HIGH     8'h18
`define ADDR_COL_PULL_LOW      8'h19
`define ADDR_COL_PULL_HIGH     8'h1A
`define ADDR_ROW_IRQ_POL       8'h1B
`define ROW_PULL_HIGH_MASK     8'h0F
`define ROW5_PULL_MASK         8'h0C
`define COL_PULL_HIGH_MASK     8'h03
`define ROW_IRQ_POL_MASK       8'h3F
`define INPUT6_POL_MASK        8'h20
`define PULL_RESET             8'h00
`define ROW_IRQ_POL_RESET      8'h00
`define ROW_COUNT              6
`define COL_COUNT              5
`endif

// ==== gpi_pull_pkg.sv ====
// Purpose: types shared by the pull/level slice
// Assumes: nothing beyond the params header
// Notes:   pull field encodings
package gpi_pull_pkg;
   typedef enum logic [1:0] {
      PULL_UP_300K   = 2'b00,
      PULL_DOWN_300K = 2'b01,
      PULL_UP_100K   = 2'b10,
      PULL_OFF       = 2'b11
   } pull_mode_t;
endpackage : gpi_pull_pkg

// ==== pin_sync.sv ====
// Purpose: three-flop synchroniser with agreement filter for pin levels
// Assumes: pins are asynchronous to core_clk_in
// Notes:   first stage feeds only the second
module pin_sync #(parameter int WIDTH = 1) (
   // Clock and reset
   input  wire logic             core_clk_in,
   input  wire logic             rst_in,
   // Pins
   input  wire logic [WIDTH-1:0] pin_in,
   // Filtered level
   output logic      [WIDTH-1:0] level_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } sync_state_t;
   sync_state_t st;
   sync_state_t next_st;
   always_comb begin
      next_st    = st;
      next_st.s1 = pin_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // A change counts only once stages two and three agree
      for (int i = 0; i < WIDTH; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.lvl[i] = st.s3[i];
         end
      end
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign level_out = st.lvl;
endmodule : pin_sync

// ==== pull_decode.sv ====
// Purpose: decode one two-bit pull field into resistor enables
// Assumes: combinational, driven from register bits
// Notes:   exactly one or no enable is high
module pull_decode (
   // Field
   input  wire logic [1:0] field_in,
   // Resistor enables
   output logic            up_300k_out,
   output logic            down_300k_out,
   output logic            up_100k_out
);
   always_comb begin
      up_300k_out   = 1'b0;
      down_300k_out = 1'b0;
      up_100k_out   = 1'b0;
      case (gpi_pull_pkg::pull_mode_t'(field_in))
         gpi_pull_pkg::PULL_UP_300K:   up_300k_out   = 1'b1;
         gpi_pull_pkg::PULL_DOWN_300K: down_300k_out = 1'b1;
         gpi_pull_pkg::PULL_UP_100K:   up_100k_out   = 1'b1;
         default: ;
      endcase
   end
endmodule : pull_decode

// ==== gpi_pull_checker.sv ====
// Purpose: port assertions for the pull/level slice
// Assumes: default options, no row 5 pin, no input 6
// Notes:   bound into every instance
module gpi_pull_checker (
   // Clock, reset, register port
   input wire logic       core_clk_in,
   input wire logic       rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_write_in,
   input wire logic       reg_read_in,
   input wire logic [7:0] reg_rdata_out,
   // Pull enables
   input wire logic [5:0] row_up_300k_out,
   input wire logic [5:0] row_down_300k_out,
   input wire logic [5:0] row_up_100k_out,
   input wire logic [4:0] column_up_100k_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   col_level_rsv_a: assert property (reg_read_in && reg_addr_in == 8'h16
      |=> reg_rdata_out[7:5] == 3'h0) else $error("column level high bits");
   pull_onehot_a: assert property (((row_up_300k_out & row_down_300k_out)
      | (row_up_100k_out & (row_up_300k_out | row_down_300k_out))) == 6'h00)
      else $error("two row pulls at once");
   row_pull_wr_a: assert property (reg_write_in && reg_addr_in == 8'h17
      && reg_wdata_in[7:6] == 2'h1 |-> ##2 row_down_300k_out[3])
      else $error("row 3 pull-down missing");
   row4_pull_wr_a: assert property (reg_write_in && reg_addr_in == 8'h18
      && reg_wdata_in[1:0] == 2'h3 |-> ##2 !(row_up_300k_out[4]
      || row_down_300k_out[4] || row_up_100k_out[4]))
      else $error("row 4 pull not off");
   col4_pull_wr_a: assert property (reg_write_in && reg_addr_in == 8'h1A
      && reg_wdata_in[1:0] == 2'h2 |-> ##2 column_up_100k_out[4])
      else $error("column 4 strong pull-up missing");
   row_high_rsv_a: assert property (reg_read_in && reg_addr_in == 8'h18
      |=> reg_rdata_out[7:2] == 6'h00) else $error("row pull high bits");
   row5_fixed_a: assert property (row_up_300k_out[5]
      && !row_up_100k_out[5]) else $error("row 5 pull moved");
   pol_rsv_a: assert property (reg_read_in && reg_addr_in == 8'h1B
      |=> reg_rdata_out[7:5] == 3'h0) else $error("polarity high bits");
   unmapped_zero_a: assert property (reg_read_in && reg_addr_in > 8'h1B
      |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
endmodule : gpi_pull_checker
bind gpi_pull_level_config gpi_pull_checker chk_u (
   .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
   .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
   .row_up_300k_out(row_up_300k_out), .row_down_300k_out(row_down_300k_out),
   .row_up_100k_out(row_up_100k_out),
   .column_up_100k_out(column_up_100k_out));

// ==== pin_partner.sv ====
// Purpose: switches on the row or column pins, with the pulls applied
// Assumes: bench chooses which pins it drives
// Notes:   a released pin with no pull never holds a stale level
module pin_partner #(parameter int WIDTH = 5) (
   // Clock
   input  wire logic             clk_in,
   // Drive control and pull enables
   input  wire logic [WIDTH-1:0] drive_en_in,
   input  wire logic [WIDTH-1:0] drive_val_in,
   input  wire logic [WIDTH-1:0] up_in,
   input  wire logic [WIDTH-1:0] down_in,
   input  wire logic [WIDTH-1:0] up_strong_in,
   // Pins
   output logic      [WIDTH-1:0] pin_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [WIDTH-1:0] wander = '0;
   always @(posedge clk_in) wander <= ~wander;
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         pin_out[i] = drive_en_in[i] ? drive_val_in[i] :
            (up_in[i] | up_strong_in[i]) ? 1'h1 : down_in[i] ? 1'h0 : wander[i];
      end
   end
endmodule : pin_partner

// ==== gpi_pull_level_config_test.sv ====
// Purpose: register and pin tests of the pull/level slice
// Assumes: default options
// Notes:   pins wait 8 cycles to pass the synchroniser
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module gpi_pull_level_config_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in = 0, rst_in = 1, reg_write_in = 0, reg_read_in = 0;
   logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out, d;
   logic [5:0] row_pin_in, ru, rd3, rs, row_irq_flag_out, row_val = 0;
   logic [4:0] column_pin_in, cu, cd, cs, col_val = 0, col_en = 5'h1F;
   int bad_count = 0, num_checks = 0, cycles = 0;
   logic [7:0] wv[5] = '{8'h4B, 8'hFF, 8'hE4, 8'hFE, 8'hFF};
   logic [7:0] ev[5] = '{8'h4B, 8'h03, 8'hE4, 8'h02, 8'h1F};
   gpi_pull_level_config dut_u (.core_clk_in(core_clk_in), .rst_in(rst_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
      .reg_rdata_out(reg_rdata_out), .row_pin_in(row_pin_in),
      .column_pin_in(column_pin_in), .row_up_300k_out(ru),
      .row_down_300k_out(rd3), .row_up_100k_out(rs), .column_up_300k_out(cu),
      .column_down_300k_out(cd), .column_up_100k_out(cs),
      .row_irq_flag_out(row_irq_flag_out));
   pin_partner #(.WIDTH(6)) rows_u (.clk_in(core_clk_in), .drive_en_in(6'h3F),
      .drive_val_in(row_val), .up_in(ru), .down_in(rd3), .up_strong_in(rs),
      .pin_out(row_pin_in));
   pin_partner #(.WIDTH(5)) cols_u (.clk_in(core_clk_in), .drive_en_in(col_en),
      .drive_val_in(col_val), .up_in(cu), .down_in(cd), .up_strong_in(cs),
      .pin_out(column_pin_in));
   always #5 core_clk_in = ~core_clk_in;
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim
   // A hang ends the run as a failure
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         end_sim();
      end
   end
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk_in) {reg_addr_in, reg_wdata_in, reg_write_in} <= {a, v, 1'h1};
      @(posedge core_clk_in) reg_write_in <= 1'h0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge core_clk_in) {reg_addr_in, reg_read_in} <= {a, 1'h1};
      @(posedge core_clk_in) reg_read_in <= 1'h0;
      #1 d = reg_rdata_out;
   endtask : rd
   initial begin
      repeat (16) @(posedge core_clk_in);
      rst_in <= 1'h0;
      #1 `CHK("reset pulls", 11'h7FF, {ru, cu})
      for (int i = 0; i < 5; i++) begin
         rd(8'h17 + i); `CHK("reset value", 8'h00, d)
      end
      for (int i = 0; i < 5; i++) wr(8'h17 + i, wv[i]);
      wr(8'h30, 8'hFF);
      rd(8'h30); `CHK("unmapped", 8'h00, d)
      for (int i = 0; i < 5; i++) begin
         rd(8'h17 + i); `CHK("readback", ev[i], d)
      end
      `CHK("row pulls", 18'h24202, {ru, rd3, rs})
      `CHK("col pulls", 15'h0454, {cu, cd, cs})
      @(posedge core_clk_in) col_en <= 5'h18;
      repeat (8) @(posedge core_clk_in);
      rd(8'h16); `CHK("pulled cols", 3'h5, d[2:0])
      @(posedge core_clk_in) {col_en, col_val} <= {5'h1F, 5'h16};
      repeat (8) @(posedge core_clk_in);
      rd(8'h16); `CHK("col level", 8'h16, d)
      @(posedge core_clk_in) col_val <= 5'h09;
      repeat (8) @(posedge core_clk_in);
      rd(8'h16); `CHK("col level", 8'h09, d)
      // Flags latched while polarity was still low are flushed first
      rd(8'h13);
      @(posedge core_clk_in) row_val <= 6'h21;
      repeat (8) @(posedge core_clk_in);
      rd(8'h13); `CHK("flags", 8'h01, d)
      rd(8'h13); `CHK("flags", 8'h01, d)
      @(posedge core_clk_in) row_val <= 6'h20;
      repeat (8) @(posedge core_clk_in);
      rd(8'h13); `CHK("flags", 8'h01, d)
      rd(8'h13); `CHK("flags", 8'h00, d)
      `CHK("flag pins", 6'h00, row_irq_flag_out)
      end_sim();
   end
endmodule : gpi_pull_level_config_test
